/* include/iahr_regs.vh */
/*
 * register offsets, field positions and reset values of the host register map.
 * assumes byte addresses on a 16-bit word bus, the byte enables be_i select the byte lane.
 */
`ifndef IAHR_REGS_VH
`define IAHR_REGS_VH

`define IAHR_OFF_TGT_HI     8'h0A
`define IAHR_OFF_TGT_LO     8'h0C
`define IAHR_OFF_REV        8'h0E
`define IAHR_OFF_NVW_HI     8'h10
`define IAHR_OFF_NVW_LO     8'h12
`define IAHR_OFF_CSR_BASE   8'h20
`define IAHR_OFF_DATA_BASE  8'h40
`define IAHR_OFF_OFS_BASE   8'h80
`define IAHR_OFF_GAIN_BASE  8'hC0

`define IAHR_TGT_RST        16'h0000
`define IAHR_CSR_RST_NORM   16'h0807
`define IAHR_CSR_RST_LOW    16'h0A07
`define IAHR_CSR_WMASK      16'hEF07

`define IAHR_BIT_FMT        15
`define IAHR_BIT_EXC        14
`define IAHR_BIT_OPEN       13
`define IAHR_RNG_HI         11
`define IAHR_RNG_LO         8
`define IAHR_FC_HI          2
`define IAHR_FC_LO          0

`define IAHR_RNG_BIP_BIT    3
`define IAHR_RNG_RSVD       4'h7
`define IAHR_RNG_LOWONLY    4'h6
`define IAHR_MID_SCALE      16'h8000

`endif

/* src/iahr_csr_chan.v */
/*
 * one channel control/status word with open-sensor self-clear.
 * assumes the detection engine pulses done_i once per detection.
 */
`timescale 1ns/10ps
`include "iahr_regs.vh"

module iahr_csr_chan #(
    parameter LOW_LEVEL = 0
) (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        rst_i,
    // host write
    input  wire        wr_i,
    input  wire [1:0]  be_i,
    input  wire [15:0] wdata_i,
    // detection completion
    input  wire        done_i,
    // word
    output reg  [15:0] csr_o
);

    // ==========================================================
    // write with lane enables, reserved bits kept zero
    // ==========================================================
    reg  [15:0] merged;
    reg  [15:0] csr_nxt;

    always @* begin
        merged = csr_o;
        if (be_i[1]) begin
            merged[15:8] = wdata_i[15:8];
        end
        if (be_i[0]) begin
            merged[7:0] = wdata_i[7:0];
        end
        merged = merged & `IAHR_CSR_WMASK;
        if (merged[`IAHR_RNG_HI:`IAHR_RNG_LO] == `IAHR_RNG_RSVD) begin
            merged[`IAHR_RNG_HI:`IAHR_RNG_LO] = csr_o[`IAHR_RNG_HI:`IAHR_RNG_LO];
        end
        if (LOW_LEVEL == 0 && merged[`IAHR_RNG_HI:`IAHR_RNG_LO] == `IAHR_RNG_LOWONLY) begin
            merged[`IAHR_RNG_HI:`IAHR_RNG_LO] = csr_o[`IAHR_RNG_HI:`IAHR_RNG_LO];
        end
        csr_nxt = wr_i ? merged : csr_o;
        if (done_i && !(wr_i && be_i[1] && wdata_i[`IAHR_BIT_OPEN])) begin
            csr_nxt[`IAHR_BIT_OPEN] = 1'b0;
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            csr_o <= (LOW_LEVEL != 0) ? `IAHR_CSR_RST_LOW : `IAHR_CSR_RST_NORM;
        end else begin
            csr_o <= csr_nxt;
        end
    end

endmodule // iahr_csr_chan

/* src/iahr_fmt.v */
/*
 * formats one corrected sample as the channel word selects.
 * assumes the sample arrives as offset binary from the correction engine.
 */
`timescale 1ns/10ps
`include "iahr_regs.vh"

module iahr_fmt (
    // inputs
    input  wire [15:0] raw_i,
    input  wire [15:0] csr_i,
    // formatted word
    output wire [15:0] word_o
);

    // ==========================================================
    // format select
    // ==========================================================
    wire bipolar = csr_i[`IAHR_RNG_HI];
    wire twos    = csr_i[`IAHR_BIT_FMT];

    assign word_o = (bipolar && twos) ? (raw_i ^ `IAHR_MID_SCALE) : raw_i;

endmodule // iahr_fmt

/* src/iahr_regmap.v */
/*
 * host register map: calibration target, revision, write count, channel words,
 * corrected data area and coefficient copies.
 * assumes a synchronous 16-bit host port; reads answer one cycle after the strobe.
 */
// Operation
// - calibration target held as two writable words at 0x0A/0x0C, reset zero.
// - target value and readings feed coefficient derivation per channel.
// - read-only revision at 0x0E, major upper byte, minor lower byte.
// - read-only 32-bit nonvolatile write count at 0x10 and 0x12.
// - every channel has its own word; channel zero at 0x20, reset 0x0807, or 0x0A07 on low-level boards.
// - format bit picks offset binary or two's complement, bipolar only.
// - excitation bit drives the channel sensor supply enable.
// - open-sensor bit starts detection and clears itself on completion.
// - range field selects gain; code seven is reserved.
// - default range eight, or A on low-level boards; code six low-level only.
// - filter field selects cutoff, default code 111.
// - formatted results at 0x40 to 0x5F, one word per channel.
// - offset coefficient copies at 0x80 to 0xBC after calibration.
// - gain coefficient copies at 0xC0 to 0xFC after calibration.
// - pass/fail bit one means failed, zero means passed.
`timescale 1ns/10ps
`include "iahr_regs.vh"

module iahr_regmap #(
    parameter NCH       = 16,
    parameter LOW_LEVEL = 0,
    parameter [15:0] REV_WORD = 16'h0100  // arbitrary value
) (
    // clock and reset
    input  wire            ref_clk_i,
    input  wire            rst_i,
    // host port
    input  wire            rd_i,
    input  wire            wr_i,
    input  wire [7:0]      addr_i,
    input  wire [1:0]      be_i,
    input  wire [15:0]     wdata_i,
    output reg  [15:0]     rdata_o,
    output reg             rvalid_o,
    // nonvolatile write events
    input  wire            nv_write_i,
    // correction engine results
    input  wire            res_we_i,
    input  wire [3:0]      res_ch_i,
    input  wire [15:0]     res_raw_i,
    // coefficient copies from calibration
    input  wire            coef_we_i,
    input  wire            coef_gain_i,
    input  wire [3:0]      coef_ch_i,
    input  wire [31:0]     coef_i,
    // open-sensor detection
    input  wire [NCH-1:0]  open_done_i,
    input  wire [NCH-1:0]  open_fail_i,
    // channel controls
    output reg  [NCH-1:0]  excite_o,
    output reg  [NCH-1:0]  open_start_o,
    output reg  [NCH*4-1:0] range_o,
    output reg  [NCH*3-1:0] cutoff_o,
    output reg  [31:0]     cal_target_value_o,
    output reg  [NCH-1:0]  channel_pass_fail_o
);

    // ==========================================================
    // address helpers
    // ==========================================================
    function in_area;
        input [7:0] a;
        input [7:0] base;
        input [7:0] span;
        begin
            in_area = (a >= base) && ({1'b0, a} < ({1'b0, base} + {1'b0, span}));
        end
    endfunction

    localparam [7:0] CSR_SPAN  = 8'h20;
    localparam [7:0] DATA_SPAN = 8'h20;
    localparam [7:0] COEF_SPAN = 8'h40;

    wire [3:0] word_idx = addr_i[4:1];
    wire [3:0] coef_idx = addr_i[5:2];

    // ==========================================================
    // calibration target
    // ==========================================================
    reg [15:0] target_upper_bits_r;
    reg [15:0] target_lower_bits_r;

    function [15:0] lane_merge;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  be;
        begin
            lane_merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            target_upper_bits_r <= `IAHR_TGT_RST;
            target_lower_bits_r <= `IAHR_TGT_RST;
        end else if (wr_i) begin
            if (addr_i == `IAHR_OFF_TGT_HI) begin
                target_upper_bits_r <= lane_merge(target_upper_bits_r, wdata_i, be_i);
            end
            if (addr_i == `IAHR_OFF_TGT_LO) begin
                target_lower_bits_r <= lane_merge(target_lower_bits_r, wdata_i, be_i);
            end
        end
    end

    // ==========================================================
    // nonvolatile write counter
    // ==========================================================
    reg [31:0] nv_count_r;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            nv_count_r <= 32'h00000000;
        end else if (nv_write_i) begin
            nv_count_r <= nv_count_r + 32'h00000001;
        end
    end

    // ==========================================================
    // channel words, data area, coefficient copies
    // ==========================================================
    wire [NCH*16-1:0] csr_flat;
    wire [15:0]       res_fmt;
    reg  [15:0]       data_mem [0:NCH-1];
    reg  [31:0]       ofs_mem  [0:NCH-1];
    reg  [31:0]       gain_mem [0:NCH-1];
    reg  [15:0]       res_csr;

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            wire sel = wr_i && in_area(addr_i, `IAHR_OFF_CSR_BASE, CSR_SPAN) &&
                       (word_idx == g);
            iahr_csr_chan #(
                .LOW_LEVEL (LOW_LEVEL)
            ) u_csr (
                .ref_clk_i (ref_clk_i),
                .rst_i     (rst_i),
                .wr_i      (sel),
                .be_i      (be_i),
                .wdata_i   (wdata_i),
                .done_i    (open_done_i[g]),
                .csr_o     (csr_flat[g*16 +: 16])
            );
        end
    endgenerate

    integer k;
    integer j;
    integer n;
    always @* begin
        res_csr = 16'h0000;
        for (k = 0; k < NCH; k = k + 1) begin
            if (res_ch_i == k[3:0]) begin
                res_csr = csr_flat[k*16 +: 16];
            end
        end
    end

    iahr_fmt u_fmt (
        .raw_i  (res_raw_i),
        .csr_i  (res_csr),
        .word_o (res_fmt)
    );

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (j = 0; j < NCH; j = j + 1) begin
                data_mem[j] <= 16'h0000;
                ofs_mem[j]  <= 32'h00000000;
                gain_mem[j] <= 32'h00000000;
            end
        end else begin
            if (res_we_i) begin
                data_mem[res_ch_i] <= res_fmt;
            end
            if (coef_we_i && !coef_gain_i) begin
                ofs_mem[coef_ch_i] <= coef_i;
            end
            if (coef_we_i && coef_gain_i) begin
                gain_mem[coef_ch_i] <= coef_i;
            end
        end
    end

    // ==========================================================
    // pass/fail and channel control outputs
    // ==========================================================
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            channel_pass_fail_o <= {NCH{1'b0}};
            excite_o            <= {NCH{1'b0}};
            open_start_o        <= {NCH{1'b0}};
            range_o             <= {NCH*4{1'b0}};
            cutoff_o            <= {NCH*3{1'b0}};
            cal_target_value_o  <= 32'h00000000;
        end else begin
            for (n = 0; n < NCH; n = n + 1) begin
                if (open_done_i[n]) begin
                    channel_pass_fail_o[n] <= open_fail_i[n];
                end
                excite_o[n]       <= csr_flat[n*16 + `IAHR_BIT_EXC];
                open_start_o[n]   <= csr_flat[n*16 + `IAHR_BIT_OPEN];
                range_o[n*4 +: 4] <= csr_flat[n*16 + `IAHR_RNG_LO +: 4];
                cutoff_o[n*3 +: 3] <= csr_flat[n*16 + `IAHR_FC_LO +: 3];
            end
            cal_target_value_o <= {target_upper_bits_r, target_lower_bits_r};
        end
    end

    // ==========================================================
    // read path
    // ==========================================================
    reg [15:0] rd_nxt;

    always @* begin
        rd_nxt = 16'h0000;
        case (addr_i)
            `IAHR_OFF_TGT_HI: rd_nxt = target_upper_bits_r;
            `IAHR_OFF_TGT_LO: rd_nxt = target_lower_bits_r;
            `IAHR_OFF_REV:    rd_nxt = REV_WORD;
            `IAHR_OFF_NVW_HI: rd_nxt = nv_count_r[31:16];
            `IAHR_OFF_NVW_LO: rd_nxt = nv_count_r[15:0];
            default: begin
                if (in_area(addr_i, `IAHR_OFF_CSR_BASE, CSR_SPAN)) begin
                    rd_nxt = csr_flat[word_idx*16 +: 16];
                end else if (in_area(addr_i, `IAHR_OFF_DATA_BASE, DATA_SPAN)) begin
                    rd_nxt = data_mem[word_idx];
                end else if (in_area(addr_i, `IAHR_OFF_OFS_BASE, COEF_SPAN)) begin
                    rd_nxt = addr_i[1] ? ofs_mem[coef_idx][15:0] : ofs_mem[coef_idx][31:16];
                end else if (in_area(addr_i, `IAHR_OFF_GAIN_BASE, COEF_SPAN)) begin
                    rd_nxt = addr_i[1] ? gain_mem[coef_idx][15:0] : gain_mem[coef_idx][31:16];
                end
            end
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o  <= 16'h0000;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
            rdata_o  <= rd_i ? rd_nxt : 16'h0000;
        end
    end

endmodule // iahr_regmap

/* bench/iahr_regmap_chk_asserts.sv */
/* port checks of the host register map
   assumes a bind onto iahr_regmap, one clock, synchronous reset */
`timescale 1ns/10ps
module iahr_regmap_chk #(
    parameter NCH = 16,
    parameter LOW_LEVEL = 0,
    parameter [15:0] REV_WORD = 16'h0100
) (
    // clock, reset, host port
    input logic             ref_clk_i,
    input logic             rst_i,
    input logic             rd_i,
    input logic             wr_i,
    input logic [7:0]       addr_i,
    input logic [1:0]       be_i,
    input logic [15:0]      wdata_i,
    input logic [15:0]      rdata_o,
    input logic             rvalid_o,
    // channel side
    input logic [NCH-1:0]   open_done_i,
    input logic [NCH-1:0]   open_fail_i,
    input logic [NCH-1:0]   excite_o,
    input logic [NCH-1:0]   open_start_o,
    input logic [NCH*4-1:0] range_o,
    input logic [NCH*3-1:0] cutoff_o,
    input logic [31:0]      cal_target_value_o,
    input logic [NCH-1:0]   channel_pass_fail_o
);
// ==========================================
// assertions
default clocking @(posedge ref_clk_i); endclocking
default disable iff (rst_i);
chk_rev_read: assert property (rd_i && addr_i[7:1] == 7'h07 |=> rvalid_o && rdata_o == REV_WORD)
    else $error("revision read wrong");
chk_target_upper: assert property (wr_i && addr_i[7:1] == 7'h05 && be_i == 2'b11
    |=> ##1 cal_target_value_o[31:16] == $past(wdata_i, 2)) else $error("target upper not written");
chk_reset_defaults: assert property ($fell(rst_i) |=> range_o[3:0] == ((LOW_LEVEL != 0) ? 4'hA : 4'h8)
    && cutoff_o[2:0] == 3'h7)
    else $error("channel defaults wrong");
chk_excite_copy: assert property (wr_i && addr_i[7:1] == 7'h10 && be_i[1]
    |=> ##1 excite_o[0] == $past(wdata_i[14], 2)) else $error("excitation not following word");
chk_range_refused: assert property (wr_i && addr_i[7:1] == 7'h10 && be_i[1] && wdata_i[11:8] == 4'h7
    |=> ##1 $stable(range_o[3:0])) else $error("reserved range taken");
chk_cutoff_copy: assert property (wr_i && addr_i[7:1] == 7'h10 && be_i[0]
    |=> ##1 cutoff_o[2:0] == $past(wdata_i[2:0], 2)) else $error("cutoff not following word");
chk_fail_latch: assert property (open_done_i[0] && open_fail_i[0] |-> ##[1:2] channel_pass_fail_o[0])
    else $error("failure not reported");
chk_open_clear: assert property (open_done_i[0] && !(wr_i && addr_i[7:1] == 7'h10)
    |=> ##1 !open_start_o[0]) else $error("open bit not cleared");
endmodule // iahr_regmap_chk
bind iahr_regmap iahr_regmap_chk #(.NCH(NCH), .LOW_LEVEL(LOW_LEVEL), .REV_WORD(REV_WORD)) u_chk (.*);

/* bench/iahr_host.sv */
/* host bus master model: one-cycle read and write strobes
   assumes the register map takes every strobe at the next edge */
`timescale 1ns/10ps
module iahr_host (
    // clock and answer
    input  logic        ref_clk_i,
    input  logic        rvalid_i,
    input  logic [15:0] rdata_i,
    // request
    output logic        rd_o = 1'b0,
    output logic        wr_o = 1'b0,
    output logic [7:0]  addr_o = 8'h00,
    output logic [1:0]  be_o = 2'h0,
    output logic [15:0] wdata_o = 16'h0000
);
// ==========================================
// bus cycles, released address, enables and data show inverted values, both strobes drop low
task automatic put(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d, input logic r);
    @(posedge ref_clk_i);
    #1;
    {rd_o, wr_o, addr_o, be_o, wdata_o} = {r, ~r, a, b, d};
    @(posedge ref_clk_i);
    #1;
    {rd_o, wr_o, addr_o, be_o, wdata_o} = {2'b00, ~a, ~b, ~d};
endtask
task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    put(a, b, (a[7:5] == 3'b001) ? (d & 16'hEF07) : d, 1'b0);
endtask
task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    put(a, 2'b11, 16'h0000, 1'b1);
    d = rdata_i;
    v = rvalid_i;
endtask
endmodule // iahr_host

/* bench/testbench.sv */
/* self-checking bench of the host register map
   assumes the host model drives the bus and this bench the engine side */
`timescale 1ns/10ps
module testbench;
logic        ref_clk_i = 1'b0;
logic        rst_i = 1'b1;
logic        rd_i, wr_i, rvalid_o;
logic [7:0]  addr_i;
logic [1:0]  be_i;
logic [15:0] wdata_i, rdata_o;
logic        nv_write_i = 0, res_we_i = 0, coef_we_i = 0, coef_gain_i = 0;
logic [3:0]  res_ch_i = 0, coef_ch_i = 0;
logic [15:0] res_raw_i = 0, open_done_i = 0, open_fail_i = 0;
logic [31:0] coef_i = 0, cal_target_value_o;
logic [15:0] excite_o, open_start_o, channel_pass_fail_o;
logic [63:0] range_o, lo_range_o;
logic [47:0] cutoff_o;
integer      bad_count = 0, total_checks = 0;
always #5 ref_clk_i = ~ref_clk_i;
iahr_regmap DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i),
    .be_i(be_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .nv_write_i(nv_write_i),
    .res_we_i(res_we_i), .res_ch_i(res_ch_i), .res_raw_i(res_raw_i), .coef_we_i(coef_we_i),
    .coef_gain_i(coef_gain_i), .coef_ch_i(coef_ch_i), .coef_i(coef_i), .open_done_i(open_done_i),
    .open_fail_i(open_fail_i), .excite_o(excite_o), .open_start_o(open_start_o), .range_o(range_o),
    .cutoff_o(cutoff_o), .cal_target_value_o(cal_target_value_o), .channel_pass_fail_o(channel_pass_fail_o));
iahr_host host (.ref_clk_i(ref_clk_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o), .rd_o(rd_i), .wr_o(wr_i),
    .addr_o(addr_i), .be_o(be_i), .wdata_o(wdata_i));
iahr_regmap #(.LOW_LEVEL(1)) DUT_LOW (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .rd_i(rd_i), .wr_i(wr_i),
    .addr_i(addr_i), .be_i(be_i), .wdata_i(wdata_i), .rdata_o(), .rvalid_o(), .nv_write_i(nv_write_i),
    .res_we_i(res_we_i), .res_ch_i(res_ch_i), .res_raw_i(res_raw_i), .coef_we_i(coef_we_i),
    .coef_gain_i(coef_gain_i), .coef_ch_i(coef_ch_i), .coef_i(coef_i), .open_done_i(open_done_i),
    .open_fail_i(open_fail_i), .excite_o(), .open_start_o(), .range_o(lo_range_o),
    .cutoff_o(), .cal_target_value_o(), .channel_pass_fail_o());
// ==========================================
// helpers
task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
        bad_count++;
        $display("BAD %0t seen %h expected %h", $time, s, e);
    end
endtask
task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
endtask
task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    host.rd(a, d, v);
    chk(v, 1'b1);
    chk(d, e);
endtask
task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
// ==========================================
// scenarios
task automatic t_reset;
    rdc(8'h20, 16'h0807);
    rdc(8'h3E, 16'h0807);
    rdc(8'h0A, 16'h0000);
    rdc(8'h10, 16'h0000);
    rdc(8'h02, 16'h0000);
    chk(range_o[63:60], 4'h8);
    chk(lo_range_o[3:0], 4'hA);
    chk(cutoff_o[2:0], 3'h7);
    $display("reset test done");
endtask
task automatic t_target;
    host.wr(8'h0A, 2'b11, 16'h3999);
    host.wr(8'h0C, 2'b01, 16'h9999);
    rdc(8'h0C, 16'h0099);
    host.wr(8'h0C, 2'b10, 16'h9999);
    tick(1);
    chk(cal_target_value_o, 32'h3999_9999);
    $display("target test done");
endtask
task automatic t_readonly;
    host.wr(8'h0E, 2'b11, 16'hFFFF);
    rdc(8'h0E, 16'h0100);
    repeat (3) begin
        nv_write_i = 1'b1;
        tick(1);
        nv_write_i = 1'b0;
        tick(1);
    end
    host.wr(8'h12, 2'b11, 16'h0000);
    rdc(8'h12, 16'h0003);
    rdc(8'h10, 16'h0000);
    $display("read-only test done");
endtask
task automatic t_modes;
    logic [3:0] er;
    er = 4'h8;
    for (int c = 0; c < 16; c++) begin
        host.wr(8'h20, 2'b11, {1'b0, c[0], 2'b00, c[3:0], 5'b00000, c[2:0]});
        if (c != 6 && c != 7)
            er = c[3:0];
        tick(1);
        if (c == 6)
            chk(lo_range_o[3:0], 4'h6);
        chk(excite_o[0], c[0]);
        chk(range_o[3:0], er);
        chk(cutoff_o[2:0], c[2:0]);
    end
    $display("mode test done");
endtask
task automatic t_open(input logic f);
    host.wr(8'h20, 2'b11, 16'h2A07);
    tick(1);
    chk(open_start_o[0], 1'b1);
    {open_done_i[0], open_fail_i[0]} = {1'b1, f};
    tick(1);
    open_done_i[0] = 1'b0;
    tick(2);
    rdc(8'h20, 16'h0A07);
    chk(channel_pass_fail_o[0], f);
    $display("open-sensor test done");
endtask
task automatic t_data;
    host.wr(8'h26, 2'b11, 16'h8807);
    host.wr(8'h20, 2'b11, 16'h8007);
    tick(2);
    {res_we_i, res_ch_i, res_raw_i} = {1'b1, 4'h3, 16'h8123};
    tick(1);
    res_ch_i = 4'h0;
    tick(1);
    res_we_i = 1'b0;
    rdc(8'h46, 16'h0123);
    rdc(8'h40, 16'h8123);
    {coef_we_i, coef_gain_i, coef_ch_i, coef_i} = {2'b11, 4'h1, 32'h1234_5678};
    tick(1);
    {coef_gain_i, coef_ch_i, coef_i} = {1'b0, 4'hF, 32'h89AB_CDEF};
    tick(1);
    coef_we_i = 1'b0;
    rdc(8'hC4, 16'h1234);
    rdc(8'hC6, 16'h5678);
    rdc(8'hBC, 16'h89AB);
    rdc(8'hBE, 16'hCDEF);
    $display("data test done");
endtask
// ==========================================
// main sequence and hang guard
initial begin
    tick(12);
    rst_i = 1'b0;
    t_reset;
    t_target;
    t_readonly;
    t_modes;
    t_open(1'b1);
    t_open(1'b0);
    t_data;
    tally_and_finish;
end
initial begin
    #500000;
    bad_count++;
    $display("BAD %0t run did not end", $time);
    tally_and_finish;
end
endmodule // testbench
